// *** src/dmaeq_pkg.sv ***
// Package: constants and types for the DMA event queue and burst splitter
// Functional notes
// - Software maps each channel to one queue
// - Empty queue and idle controller bypass
// - Each queue is 16-entry circular FIFO
// - Entries readable, hold type and channel
// - Status shows head index of oldest
// - Status shows live valid entry count
// - Per-queue threshold settable 0 to 15
// - High mark keeps maximum valid count
// - Over threshold sets error and status
// - Any error flag raises error interrupt
// - At most 4 requests outstanding per controller
// - Staging buffer of 128 or 256 bytes
// - Read and write buses 8 bytes
// - Burst limit 16, 32, 64; reset 16
// - No command exceeds burst limit
// - First command aligns later ones
// - Commands as large as allowed
// - Arrays split and processed in order
// - Lowest numbered queue dequeues first
// - Dequeue only when controller accepts
// - Full queue leaves event pending
package dmaeq_pkg;
   localparam int NUM_QUEUES = 2;
   localparam int QUEUE_DEPTH = 16;
   localparam int NUM_DMA_CH = 8;
   localparam int NUM_QUICK_CH = 4;
   localparam int DEST_SLOTS = 4;
   // Far-side buffer and bus sizes; no data path in this block uses them yet
   localparam int STAGING_BYTES = 128;
   localparam int DATA_BUS_BYTES = 8;
   // Register byte offsets
   localparam logic [11:0] OFS_DMA_MAP = 12'h000;
   localparam logic [11:0] OFS_QUICK_MAP = 12'h004;
   localparam logic [11:0] OFS_THRESH = 12'h008;
   localparam logic [11:0] OFS_CTRL_ERR = 12'h00C;
   localparam logic [11:0] OFS_ERR_CLEAR = 12'h010;
   localparam logic [11:0] OFS_BURST = 12'h014;
   localparam logic [11:0] OFS_STATUS0 = 12'h040;
   localparam logic [11:0] OFS_ENTRY0 = 12'h100;
   // Status field positions
   localparam int ST_HEAD_LSB = 0;
   localparam int ST_COUNT_LSB = 8;
   localparam int ST_MARK_LSB = 16;
   localparam int ST_OVER_BIT = 24;
   // Entry field positions
   localparam int EN_TYPE_LSB = 6;
   // Burst limit encodings and reset value
   localparam logic [1:0] BURST_16 = 2'h0;
   localparam logic [1:0] BURST_32 = 2'h1;
   localparam logic [1:0] BURST_64 = 2'h2;
   localparam logic [1:0] BURST_RESET = BURST_16;
   localparam logic [3:0] THRESH_RESET = 4'h0;
   typedef enum logic [1:0] {
      DMAEQ_TRIG_EVENT = 2'b00,
      DMAEQ_TRIG_MANUAL = 2'b01,
      DMAEQ_TRIG_CHAIN = 2'b10,
      DMAEQ_TRIG_QUICK = 2'b11
   } dmaeq_trig_e;
   typedef enum logic [0:0] {
      DMAEQ_SPLIT_IDLE = 1'b0,
      DMAEQ_SPLIT_BUSY = 1'b1
   } dmaeq_split_e;
endpackage

// *** src/dmaeq_top.sv ***
// Module: event queues with threshold tracking and burst command splitter
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/10ps
module dmaeq_top #(
   parameter int NQ = dmaeq_pkg::NUM_QUEUES,
   parameter int DEPTH = dmaeq_pkg::QUEUE_DEPTH,
   parameter int SLOTS = dmaeq_pkg::DEST_SLOTS
) (
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event input: one at a time, held until taken
   input wire logic ev_valid,
   input wire logic ev_quick,
   input wire logic [1:0] ev_type,
   input wire logic [5:0] ev_channel,
   output logic ev_taken,
   // Request to parameter processing (dequeued or bypassed)
   output logic req_valid,
   output logic [0:0] req_queue,
   output logic [7:0] req_entry,
   output logic req_bypass,
   // Completion of a whole request by the transfer controller
   input wire logic [NQ-1:0] req_done,
   // Transfer request to be fragmented
   input wire logic xfer_valid,
   input wire logic [31:0] xfer_addr,
   input wire logic [15:0] xfer_array_bytes,
   input wire logic [15:0] xfer_array_count,
   input wire logic [31:0] xfer_array_stride,
   output logic xfer_ready,
   output logic cmd_valid,
   output logic [31:0] cmd_addr,
   output logic [6:0] cmd_len,
   input wire logic cmd_ready,
   output logic error_irq
);
   localparam int PW = $clog2(DEPTH);
   localparam int SW = $clog2(SLOTS + 1);

   // Configuration registers
   logic [dmaeq_pkg::NUM_DMA_CH-1:0] dma_channel_queue_map;
   logic [dmaeq_pkg::NUM_QUICK_CH-1:0] quick_channel_queue_map;
   logic [3:0] queue_threshold_setting [NQ];
   logic [1:0] burst_limit_bytes;
   logic [NQ-1:0] queue_over_threshold_error;
   // Queue state
   logic [7:0] queue_entry_view [NQ][DEPTH];
   logic [PW-1:0] head_index [NQ];
   logic [PW:0] valid_entry_count [NQ];
   logic [PW:0] usage_high_mark [NQ];
   logic [NQ-1:0] over_threshold_flag;
   logic [SW-1:0] outstanding [NQ];

   // Event routing
   wire [7:0] ev_word = {ev_type, ev_channel};
   wire ev_q = ev_quick ? quick_channel_queue_map[ev_channel[1:0]]
                        : dma_channel_queue_map[ev_channel[2:0]];
   wire [PW:0] ev_cnt = valid_entry_count[ev_q];
   wire ev_idle = (ev_cnt == '0) && (outstanding[ev_q] == '0);
   wire ev_full = (ev_cnt == (PW+1)'(DEPTH));
   // A held event is ignored while its ev_taken pulse shows, so it is never taken twice
   wire ev_new = ev_valid && !ev_taken;
   wire ev_bypass = ev_new && ev_idle;
   wire ev_enq = ev_new && !ev_idle && !ev_full;

   // Dequeue arbitration: lowest queue that has entries and room
   logic [NQ-1:0] can_deq;
   logic [0:0] deq_q;
   logic deq_any;
   always_comb begin
      deq_any = 1'b0;
      deq_q = '0;
      for (int q = NQ - 1; q >= 0; q--) begin
         can_deq[q] = (valid_entry_count[q] != '0) &&
                      (outstanding[q] < SW'(SLOTS));
         if (can_deq[q]) begin
            deq_any = 1'b1;
            deq_q = 1'(q);
         end
      end
   end
   // Bypass takes the submission slot, dequeue waits a cycle
   wire deq_go = deq_any && !ev_bypass;

   // APB decode
   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pwrite && pready;
   wire sel_status = (paddr >= dmaeq_pkg::OFS_STATUS0) &&
                     (paddr < dmaeq_pkg::OFS_STATUS0 + 12'(4 * NQ));
   wire sel_entry = (paddr >= dmaeq_pkg::OFS_ENTRY0) &&
                    (paddr < dmaeq_pkg::OFS_ENTRY0 + 12'(4 * NQ * DEPTH));
   wire [11:0] st_off = paddr - dmaeq_pkg::OFS_STATUS0;
   wire [11:0] en_off = paddr - dmaeq_pkg::OFS_ENTRY0;
   wire [0:0] st_q = st_off[2+:1];
   wire [0:0] en_q = en_off[2+PW+:1];
   wire [PW-1:0] en_i = en_off[2+:PW];
   logic [31:0] rd_mux;
   logic rd_bad;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_bad = 1'b0;
      if (paddr == dmaeq_pkg::OFS_DMA_MAP) begin
         rd_mux = 32'(dma_channel_queue_map);
      end else if (paddr == dmaeq_pkg::OFS_QUICK_MAP) begin
         rd_mux = 32'(quick_channel_queue_map);
      end else if (paddr == dmaeq_pkg::OFS_THRESH) begin
         for (int q = 0; q < NQ; q++) rd_mux[q*8+:4] = queue_threshold_setting[q];
      end else if (paddr == dmaeq_pkg::OFS_CTRL_ERR) begin
         rd_mux = 32'(queue_over_threshold_error);
      end else if (paddr == dmaeq_pkg::OFS_ERR_CLEAR) begin
         rd_mux = 32'h0000_0000;
      end else if (paddr == dmaeq_pkg::OFS_BURST) begin
         rd_mux = 32'(burst_limit_bytes);
      end else if (sel_status) begin
         rd_mux[dmaeq_pkg::ST_HEAD_LSB+:PW] = head_index[st_q];
         rd_mux[dmaeq_pkg::ST_COUNT_LSB+:PW+1] = valid_entry_count[st_q];
         rd_mux[dmaeq_pkg::ST_MARK_LSB+:PW+1] = usage_high_mark[st_q];
         rd_mux[dmaeq_pkg::ST_OVER_BIT] = over_threshold_flag[st_q];
      end else if (sel_entry) begin
         rd_mux = 32'(queue_entry_view[en_q][en_i]);
      end else begin
         rd_bad = 1'b1;
      end
   end

   // APB answers one cycle after setup: access phase always has pready
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
         pslverr <= apb_setup && rd_bad;
      end
   end

   // Software-written configuration; write to unmapped or status is dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_channel_queue_map <= '0;
         quick_channel_queue_map <= '0;
         burst_limit_bytes <= dmaeq_pkg::BURST_RESET;
         for (int q = 0; q < NQ; q++) queue_threshold_setting[q] <= dmaeq_pkg::THRESH_RESET;
      end else if (apb_wr) begin
         if (paddr == dmaeq_pkg::OFS_DMA_MAP) begin
            dma_channel_queue_map <= pwdata[dmaeq_pkg::NUM_DMA_CH-1:0];
         end else if (paddr == dmaeq_pkg::OFS_QUICK_MAP) begin
            quick_channel_queue_map <= pwdata[dmaeq_pkg::NUM_QUICK_CH-1:0];
         end else if (paddr == dmaeq_pkg::OFS_THRESH) begin
            for (int q = 0; q < NQ; q++) queue_threshold_setting[q] <= pwdata[q*8+:4];
         end else if (paddr == dmaeq_pkg::OFS_BURST && pwdata[1:0] != 2'h3) begin
            burst_limit_bytes <= pwdata[1:0];
         end
      end
   end

   // Queue storage, pointers, counts, high mark, threshold flags
   wire err_clr = apb_wr && (paddr == dmaeq_pkg::OFS_ERR_CLEAR);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int q = 0; q < NQ; q++) begin
            head_index[q] <= '0;
            valid_entry_count[q] <= '0;
            usage_high_mark[q] <= '0;
            outstanding[q] <= '0;
            for (int e = 0; e < DEPTH; e++) queue_entry_view[q][e] <= 8'h00;
         end
         over_threshold_flag <= '0;
         queue_over_threshold_error <= '0;
      end else begin
         for (int q = 0; q < NQ; q++) begin
            logic enq_q, deq_this, sub_q, over_q;
            logic [PW:0] cnt_n;
            enq_q = ev_enq && (ev_q == 1'(q));
            deq_this = deq_go && (deq_q == 1'(q));
            sub_q = deq_this || (ev_bypass && ev_q == 1'(q));
            cnt_n = valid_entry_count[q] + (PW+1)'(enq_q) - (PW+1)'(deq_this);
            over_q = cnt_n > (PW+1)'(queue_threshold_setting[q]);
            if (enq_q) begin
               // Tail wraps naturally in PW bits
               queue_entry_view[q][head_index[q] + PW'(valid_entry_count[q])] <= ev_word;
            end
            if (deq_this) head_index[q] <= head_index[q] + 1'b1;
            valid_entry_count[q] <= cnt_n;
            if (cnt_n > usage_high_mark[q]) usage_high_mark[q] <= cnt_n;
            outstanding[q] <= outstanding[q] + SW'(sub_q) - SW'(req_done[q]);
            // Set wins over software clear
            if (over_q) begin
               over_threshold_flag[q] <= 1'b1;
               queue_over_threshold_error[q] <= 1'b1;
            end else if (err_clr && pwdata[q]) begin
               over_threshold_flag[q] <= 1'b0;
               queue_over_threshold_error[q] <= 1'b0;
            end
         end
      end
   end

   // Submission outputs and error interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_valid <= 1'b0;
         req_queue <= '0;
         req_entry <= 8'h00;
         req_bypass <= 1'b0;
         ev_taken <= 1'b0;
         error_irq <= 1'b0;
      end else begin
         req_valid <= ev_bypass || deq_go;
         req_queue <= ev_bypass ? ev_q : deq_q;
         req_entry <= ev_bypass ? ev_word : queue_entry_view[deq_q][head_index[deq_q]];
         req_bypass <= ev_bypass;
         ev_taken <= ev_bypass || ev_enq;
         error_irq <= |queue_over_threshold_error;
      end
   end

   // Burst splitter: one address generator, shared by read or write side
   function automatic logic [6:0] burst_bytes(input logic [1:0] enc);
      case (enc)
         dmaeq_pkg::BURST_32: burst_bytes = 7'd32;
         dmaeq_pkg::BURST_64: burst_bytes = 7'd64;
         default: burst_bytes = 7'd16;
      endcase
   endfunction

   dmaeq_pkg::dmaeq_split_e split_state;
   logic [31:0] cur_addr;
   logic [31:0] array_base;
   logic [15:0] bytes_left;
   logic [15:0] arrays_left;
   logic [15:0] array_len;
   logic [31:0] stride;
   wire [6:0] blim = burst_bytes(burst_limit_bytes);
   // Room up to the next burst boundary
   wire [6:0] to_edge = blim - (7'(cur_addr) & (blim - 7'd1));
   wire [6:0] this_len = (16'(to_edge) < bytes_left) ? to_edge : 7'(bytes_left);
   wire cmd_fire = cmd_valid && cmd_ready;
   wire last_piece = cmd_fire && (16'(cmd_len) == bytes_left);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         split_state <= dmaeq_pkg::DMAEQ_SPLIT_IDLE;
         cur_addr <= 32'h0000_0000;
         array_base <= 32'h0000_0000;
         bytes_left <= 16'h0000;
         arrays_left <= 16'h0000;
         array_len <= 16'h0000;
         stride <= 32'h0000_0000;
         cmd_valid <= 1'b0;
         cmd_addr <= 32'h0000_0000;
         cmd_len <= 7'h00;
         xfer_ready <= 1'b0;
      end else begin
         xfer_ready <= 1'b0;
         case (split_state)
            dmaeq_pkg::DMAEQ_SPLIT_IDLE: begin
               cmd_valid <= 1'b0;
               if (xfer_valid && !xfer_ready && xfer_array_bytes != '0 &&
                   xfer_array_count != '0) begin
                  xfer_ready <= 1'b1;
                  cur_addr <= xfer_addr;
                  array_base <= xfer_addr;
                  bytes_left <= xfer_array_bytes;
                  array_len <= xfer_array_bytes;
                  arrays_left <= xfer_array_count;
                  stride <= xfer_array_stride;
                  split_state <= dmaeq_pkg::DMAEQ_SPLIT_BUSY;
               end
            end
            dmaeq_pkg::DMAEQ_SPLIT_BUSY: begin
               if (!cmd_valid) begin
                  cmd_valid <= 1'b1;
                  cmd_addr <= cur_addr;
                  cmd_len <= this_len;
               end else if (cmd_fire) begin
                  cmd_valid <= 1'b0;
                  if (last_piece) begin
                     // Next array in order
                     if (arrays_left == 16'h0001) begin
                        split_state <= dmaeq_pkg::DMAEQ_SPLIT_IDLE;
                     end
                     arrays_left <= arrays_left - 16'h0001;
                     array_base <= array_base + stride;
                     cur_addr <= array_base + stride;
                     bytes_left <= array_len;
                  end else begin
                     cur_addr <= cur_addr + 32'(cmd_len);
                     bytes_left <= bytes_left - 16'(cmd_len);
                  end
               end
            end
            default: split_state <= dmaeq_pkg::DMAEQ_SPLIT_IDLE;
         endcase
      end
   end
endmodule

// *** bench/dmaeq_monitor.sv ***
// Checker: port relations of the event queue and burst splitter
`timescale 1ns/10ps
module dmaeq_monitor #(
   parameter int NQ = 2,
   parameter int SLOTS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ev_valid,
   input wire logic ev_taken,
   input wire logic req_valid,
   input wire logic [0:0] req_queue,
   input wire logic req_bypass,
   input wire logic [NQ-1:0] req_done,
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_addr,
   input wire logic [6:0] cmd_len,
   input wire logic cmd_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Requests in flight per queue, bypassed ones included
   logic [3:0] inflight [NQ];
   always_ff @(posedge clk or negedge rst_n) begin
      for (int q = 0; q < NQ; q++) begin
         if (!rst_n) inflight[q] <= 4'h0;
         else inflight[q] <= inflight[q] + 4'(req_valid && req_queue == q) - 4'(req_done[q]);
      end
   end
   apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
   err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
   slot_cap_a: assert property (req_valid |-> inflight[req_queue] < 4'(SLOTS)) else $error("slots");
   bypass_req_a: assert property (req_bypass |-> req_valid && ev_taken) else $error("bypass");
   taken_cause_a: assert property (ev_taken |-> $past(ev_valid)) else $error("stray take");
   burst_cap_a: assert property (cmd_valid |-> cmd_len inside {[1:64]}) else $error("len");
   burst_edge_a: assert property (cmd_valid |-> 8'(cmd_addr[5:0]) + 8'(cmd_len) <= 8'd64)
      else $error("crosses");
   cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_addr)
      && $stable(cmd_len)) else $error("dropped");
   cmd_gap_a: assert property (cmd_valid && cmd_ready |=> !cmd_valid) else $error("no gap");
endmodule
bind dmaeq_top dmaeq_monitor #(.NQ(NQ), .SLOTS(SLOTS)) mon (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .ev_valid(ev_valid),
   .ev_taken(ev_taken), .req_valid(req_valid), .req_queue(req_queue), .req_bypass(req_bypass),
   .req_done(req_done), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
   .cmd_ready(cmd_ready));

// *** bench/dmaeq_far_model.sv ***
// Far-side model: command sink with stall and request completion
`timescale 1ns/10ps
module dmaeq_far_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_addr,
   input wire logic [6:0] cmd_len,
   output logic cmd_ready,
   input wire logic req_valid,
   input wire logic [0:0] req_queue,
   input wire logic [1:0] stall,
   input wire logic hold,
   output logic [1:0] req_done
);
   logic [31:0] seen_addr [$];
   logic [6:0] seen_len [$];
   int wait_cnt;
   int owed [2];
   // Accept a held command after stall cycles, logging it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
         wait_cnt = 0;
      end else if (cmd_valid && cmd_ready) begin
         seen_addr.push_back(cmd_addr);
         seen_len.push_back(cmd_len);
         cmd_ready <= 1'b0;
         wait_cnt = 0;
      end else if (cmd_valid) begin
         cmd_ready <= (wait_cnt >= int'(stall));
         wait_cnt++;
      end
   end
   // One slot per request until completed; hold keeps slots busy
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_done <= 2'b00;
         owed = '{0, 0};
      end else begin
         for (int q = 0; q < 2; q++) begin
            if (req_valid && req_queue == q) owed[q]++;
            req_done[q] <= !hold && owed[q] > 0 && !req_done[q];
            if (!hold && owed[q] > 0 && !req_done[q]) owed[q]--;
         end
      end
   end
endmodule

// *** bench/tb_top.sv ***
// Testbench: register, event and burst scenarios for the event queue block
`timescale 1ns/10ps
module tb_top;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, byp, hold;
   logic ev_valid, ev_quick, ev_taken, req_valid, req_bypass, xfer_valid, xfer_ready;
   logic cmd_valid, cmd_ready, error_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, xfer_addr, xfer_array_stride, cmd_addr;
   logic [1:0] ev_type, req_done, stall;
   logic [5:0] ev_channel;
   logic [0:0] req_queue, qsel;
   logic [15:0] xfer_array_bytes, xfer_array_count;
   logic [6:0] cmd_len;
   logic [7:0] req_entry, ent;
   int bad_count, num_checks;
   dmaeq_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ev_valid(ev_valid), .ev_quick(ev_quick), .ev_type(ev_type), .ev_channel(ev_channel),
      .ev_taken(ev_taken), .req_valid(req_valid), .req_queue(req_queue), .req_entry(req_entry),
      .req_bypass(req_bypass), .req_done(req_done), .xfer_valid(xfer_valid),
      .xfer_addr(xfer_addr), .xfer_array_bytes(xfer_array_bytes),
      .xfer_array_count(xfer_array_count), .xfer_array_stride(xfer_array_stride),
      .xfer_ready(xfer_ready), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready), .error_irq(error_irq));
   dmaeq_far_model far (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
      .cmd_len(cmd_len), .cmd_ready(cmd_ready), .req_valid(req_valid), .req_queue(req_queue),
      .stall(stall), .hold(hold), .req_done(req_done));
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // A wait that ran out is a mismatch and ends the run
   task automatic give_up();
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
      summarize();
   endtask
   // One APB transfer; waits for pready, never a fixed count
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Offer one event, hold it until ev_taken is sampled high at an edge
   task automatic send_ev(input int i);
      int n;
      n = 0;
      @(posedge clk);
      ev_valid <= 1'b1;
      ev_quick <= (i % 4 == 3);
      ev_type <= 2'(i % 4);
      ev_channel <= 6'(i);
      do begin
         @(posedge clk);
         n++;
      end while (ev_taken !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      // Bypass submission stands in the same cycle as ev_taken
      byp = req_bypass;
      qsel = req_queue;
      ent = req_entry;
      ev_valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Two arrays of 64 bytes from an unaligned start under one burst limit
   task automatic split(input logic [1:0] code);
      int b, a, l, left, n;
      int ea[$];
      int el[$];
      b = 16 << code;
      n = 0;
      for (int j = 0; j < 2; j++) begin
         a = 31 + j * 256;
         left = 64;
         while (left > 0) begin
            l = (b - a % b < left) ? b - a % b : left;
            ea.push_back(a);
            el.push_back(l);
            a += l;
            left -= l;
         end
      end
      apb(1'b1, dmaeq_pkg::OFS_BURST, {30'h0, code}); // changed only while idle
      far.seen_addr.delete();
      far.seen_len.delete();
      stall <= code;
      xfer_valid <= 1'b1;
      xfer_addr <= 32'h0000_001F;
      xfer_array_bytes <= 16'h0040;
      xfer_array_count <= 16'h0002;
      xfer_array_stride <= 32'h0000_0100;
      do begin
         @(posedge clk);
         n++;
      end while (xfer_ready !== 1'b1 && n < 50);
      if (n >= 50) give_up();
      xfer_valid <= 1'b0;
      while (far.seen_len.size() < el.size() && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) give_up();
      repeat (4) @(posedge clk);
      check(far.seen_len.size(), el.size());
      for (int k = 0; k < el.size(); k++) begin
         check(far.seen_addr[k], ea[k]);
         check(32'(far.seen_len[k]), el[k]);
      end
   endtask
   // Main sequence; every input has a value at time zero
   initial begin
      {psel, penable, pwrite, ev_valid, ev_quick, xfer_valid, hold, rst_n} = 8'h00;
      {paddr, pwdata, ev_type, ev_channel, stall} = '0;
      {xfer_addr, xfer_array_bytes, xfer_array_count, xfer_array_stride} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, dmaeq_pkg::OFS_BURST, 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b0, dmaeq_pkg::OFS_THRESH, 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b0, 12'hFFC, 32'h0);
      check(err, 1'b1);
      for (int c = 0; c < 3; c++) split(2'(c));
      apb(1'b1, dmaeq_pkg::OFS_BURST, 32'h0000_0003);
      apb(1'b0, dmaeq_pkg::OFS_BURST, 32'h0);
      check(rd, 32'h0000_0002);
      // Far side holds completions so the queue backs up
      hold <= 1'b1;
      apb(1'b1, dmaeq_pkg::OFS_THRESH, 32'h0000_0001);
      send_ev(0);
      check(byp, 1'b1);
      for (int i = 1; i < 5; i++) send_ev(i);
      check(byp, 1'b0);
      apb(1'b0, dmaeq_pkg::OFS_STATUS0, 32'h0);
      check(rd, 32'h0001_0103);
      send_ev(5);
      apb(1'b0, dmaeq_pkg::OFS_STATUS0, 32'h0);
      check(rd, 32'h0102_0203);
      apb(1'b0, dmaeq_pkg::OFS_CTRL_ERR, 32'h0);
      check(rd, 32'h0000_0001);
      check(error_irq, 1'b1);
      hold <= 1'b0;
      repeat (20) @(posedge clk);
      apb(1'b0, dmaeq_pkg::OFS_STATUS0, 32'h0);
      check(rd, 32'h0102_0005);
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, dmaeq_pkg::OFS_ENTRY0 + 12'(4 * k), 32'h0);
         check(rd, {24'h0, 2'((k + 1) % 4), 6'(k + 1)});
      end
      apb(1'b1, dmaeq_pkg::OFS_ERR_CLEAR, 32'h0000_0001);
      apb(1'b0, dmaeq_pkg::OFS_STATUS0, 32'h0);
      check(rd, 32'h0002_0005);
      repeat (2) @(posedge clk);
      check(error_irq, 1'b0);
      apb(1'b1, dmaeq_pkg::OFS_DMA_MAP, 32'h0000_0002);
      send_ev(1);
      check(qsel, 1'b1);
      check(byp, 1'b1);
      check(ent, 8'h41);
      summarize();
   end
endmodule
